// >>> adc_seq_defs.svh
`ifndef ADC_SEQ_DEFS_SVH
`define ADC_SEQ_DEFS_SVH
`define OFF_ACTIVE 12'h000
`define OFF_RAW_INT 12'h004
`define OFF_INT_MASK 12'h008
`define OFF_INT_CLEAR 12'h00c
`define OFF_OVERFLOW 12'h010
`define OFF_TRIG_SEL 12'h014
`define OFF_UNDERFLOW 12'h018
`define OFF_PRIORITY 12'h020
`define OFF_INITIATE 12'h028
`define OFF_AVERAGE 12'h030
`define OFF_SEQ_BASE 12'h040
`define OFF_SEQ_STRIDE 12'h020
`define SUB_INPUT_SEL 3'h0
`define SUB_STEP_CTL 3'h1
`define SUB_RESULT 3'h2
`define SUB_FIFO_STAT 3'h3
`define RST_PRIORITY 32'h0000_3210
`define RST_STEP_CTL3 32'h0000_0002
`define CTL_DIFF 0
`define CTL_END 1
`define CTL_IE 2
`define CTL_TEMP 3
`define FST_EMPTY 8
`define FST_FULL 12
`define TRIG_CPU 4'h0
`define TRIG_ALWAYS 4'hf
`define SYS_CLK_KHZ 50000
`define CONV_CLK_KHZ 16667
`define CONV_DIV ((`SYS_CLK_KHZ + `CONV_CLK_KHZ - 1) / `CONV_CLK_KHZ)
`define MAX_AVG_LOG2 3'h6
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10
`endif

// >>> adc_seq_pkg.sv
package adc_seq_pkg;
  typedef enum logic [1:0] {S_IDLE, S_START, S_WAIT, S_STORE} seq_state_e;
  typedef logic [9:0] sample_t;
  typedef logic [1:0] seq_idx_t;
endpackage

// >>> adc_sample_sequencer_control.sv
// Contract
// - four sequencers: 8, 4, 4, 1 steps
// - fifo word 32 bits, result low 10
// - per step input nibble and control nibble
// - sequencer runs only while enabled
// - raw interrupt after each ie step
// - sequence ends at end-marked step
// - circular fifo, read pops oldest entry
// - status shows head, tail, full, empty
// - overflow and underflow status registers
// - converter paced at about 16.667 MHz
// - mask gates raw interrupt to controller
// - raw view and masked view
// - write one clears interrupt, zero ignored
// - concurrent triggers served by priority value
// - per sequencer trigger source select
// - initiate write starts cpu-triggered sequencer
// - average up to 64 conversions per entry
// - averaging off at reset, shared by all
// - single-ended code 0x000 to 0x3ff
// - differential pair k uses 2k and 2k+1
// - differential code offset around 0x1ff
// - priority resets to 0x0000_3210
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_sample_sequencer_control (
  input wire logic aclk, // system clock
  input wire logic aresetn, // synchronous reset
  input wire logic [11:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // byte strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [11:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read valid
  input wire logic s_axi_rready, // read ready
  input wire logic [3:0] periph_trig, // peripheral trigger pins
  output logic conv_start, // one-cycle request to converter
  output logic [2:0] conv_channel, // analog input (positive side in diff)
  output logic conv_diff, // differential conversion
  output logic conv_temp, // temperature sensor input
  input wire logic conv_done, // converter done level toggles high
  input wire adc_seq_pkg::sample_t conv_data, // converter result
  output logic [3:0] seq_irq // masked interrupt per sequencer
);
  import adc_seq_pkg::*;
  localparam logic [3:0] seq_depth [4] = '{4'h8, 4'h4, 4'h4, 4'h1};
  logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
  logic [1:0] bresp_r, rresp_r;
  logic [31:0] rdata_r;
  logic aw_full_r, w_full_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [3:0] active_r, raw_r, mask_r, ovf_r, unf_r, pend_r, irq_r;
  logic [15:0] trig_sel_r;
  logic [31:0] prio_r;
  logic [2:0] avg_r;
  logic [31:0] in_sel_r [4];
  logic [31:0] ctl_r [4];
  sample_t mem_r [4][8];
  logic [2:0] head_r [4];
  logic [2:0] tail_r [4];
  logic [3:0] cnt_r [4];
  logic [3:0] trig_s1_r, trig_s2_r, trig_s3_r;
  logic done_s1_r, done_s2_r, done_s3_r;
  sample_t data_s1_r, data_s2_r;
  seq_state_e state_r;
  seq_idx_t cur_r;
  logic [2:0] step_r;
  logic [1:0] div_r;
  logic [6:0] avg_cnt_r;
  logic [15:0] acc_r;
  logic start_r, chan_diff_r, temp_r;
  logic [2:0] chan_r;
  // bus decode
  wire wr_go = aw_full_r && w_full_r && !bvalid_r;
  wire rd_go = s_axi_arvalid && arready_r;
  wire [31:0] wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] wval = wdata_r & wmask;
  wire [11:0] wa = awaddr_r & 12'hffc;
  wire [11:0] ra = s_axi_araddr & 12'hffc;
  wire w_seq_area = wa >= `OFF_SEQ_BASE && wa < 12'h0c0;
  wire r_seq_area = ra >= `OFF_SEQ_BASE && ra < 12'h0c0;
  wire [11:0] w_rel = wa - `OFF_SEQ_BASE;
  wire [11:0] r_rel = ra - `OFF_SEQ_BASE;
  wire [1:0] w_seq = w_rel[6:5];
  wire [1:0] r_seq = r_rel[6:5];
  wire [2:0] w_sub = w_rel[4:2];
  wire [2:0] r_sub = r_rel[4:2];
  wire wr_initiate = wr_go && wa == `OFF_INITIATE;
  wire [3:0] clr_int = (wr_go && wa == `OFF_INT_CLEAR) ? wval[3:0] : 4'h0;
  wire [3:0] clr_ovf = (wr_go && wa == `OFF_OVERFLOW) ? wval[3:0] : 4'h0;
  wire [3:0] clr_unf = (wr_go && wa == `OFF_UNDERFLOW) ? wval[3:0] : 4'h0;
  wire [15:0] acc_shift = acc_r >> avg_r;
  wire sample_t avg_res = acc_shift[9:0];
  // per-sequencer trigger, fifo status and pop
  logic [3:0] trig_ev, fifo_full, fifo_empty, pop, push, unf_set, ovf_set, int_set;
  logic [31:0] fstat [4];
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_seq
      wire [3:0] sel = trig_sel_r[4*g +: 4];
      wire cpu_hit = wr_initiate && wval[g];
      wire per_hit = sel >= 4'h1 && sel <= 4'h4 && trig_s2_r[sel[1:0] - 2'd1]
                     && !trig_s3_r[sel[1:0] - 2'd1];
      assign trig_ev[g] = (sel == `TRIG_CPU && cpu_hit) || sel == `TRIG_ALWAYS || per_hit;
      assign fifo_empty[g] = cnt_r[g] == 4'h0;
      assign fifo_full[g] = cnt_r[g] == seq_depth[g];
      assign fstat[g] = {19'h0, fifo_full[g], 3'h0, fifo_empty[g], 1'b0, head_r[g], 1'b0,
                         tail_r[g]};
      wire rd_fifo = rd_go && r_seq_area && r_seq == g && r_sub == `SUB_RESULT;
      assign pop[g] = rd_fifo && !fifo_empty[g];
      assign unf_set[g] = rd_fifo && fifo_empty[g];
      assign push[g] = state_r == S_STORE && cur_r == g && avg_cnt_r == 7'h0 && !fifo_full[g];
      assign ovf_set[g] = state_r == S_STORE && cur_r == g && avg_cnt_r == 7'h0 && fifo_full[g];
      assign int_set[g] = state_r == S_STORE && cur_r == g && avg_cnt_r == 7'h0
                          && ctl_r[g][4*step_r + `CTL_IE];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          head_r[g] <= 3'h0;
          tail_r[g] <= 3'h0;
          cnt_r[g] <= 4'h0;
        end else begin
          if (push[g]) begin
            mem_r[g][head_r[g]] <= avg_res;
            head_r[g] <= (head_r[g] == 3'(seq_depth[g] - 4'h1)) ? 3'h0 : head_r[g] + 3'h1;
          end
          if (pop[g])
            tail_r[g] <= (tail_r[g] == 3'(seq_depth[g] - 4'h1)) ? 3'h0 : tail_r[g] + 3'h1;
          cnt_r[g] <= cnt_r[g] + {3'h0, push[g]} - {3'h0, pop[g]};
        end
      end
    end
  endgenerate
  // fixed priority pick among pending sequencers, lowest value wins
  logic found;
  seq_idx_t pick;
  logic [1:0] best;
  always_comb begin
    found = 1'b0;
    pick = 2'd0;
    best = 2'd3;
    for (int i = 0; i < 4; i++) begin
      if (pend_r[i] && (!found || prio_r[4*i +: 2] < best)) begin
        found = 1'b1;
        pick = seq_idx_t'(i);
        best = prio_r[4*i +: 2];
      end
    end
  end
  wire tick = div_r == 2'(`CONV_DIV - 1);
  wire done_ev = done_s2_r && !done_s3_r;
  wire [3:0] nib_in = in_sel_r[cur_r][4*step_r +: 4];
  wire [3:0] nib_ctl = ctl_r[cur_r][4*step_r +: 4];
  wire [2:0] last_step = 3'(seq_depth[cur_r] - 4'h1);
  wire seq_end = nib_ctl[`CTL_END] || step_r == last_step;
  wire [15:0] acc_sum = acc_r + {6'h0, data_s2_r};
  wire [6:0] avg_total = 7'(7'h1 << avg_r);
  wire [3:0] start_clr = (state_r == S_IDLE && found && active_r[pick]) ? 4'(4'h1 << pick) : 4'h0;
  wire [31:0] rd_val =
    ra == `OFF_ACTIVE ? {28'h0, active_r} :
    ra == `OFF_RAW_INT ? {28'h0, raw_r} :
    ra == `OFF_INT_MASK ? {28'h0, mask_r} :
    ra == `OFF_INT_CLEAR ? {28'h0, raw_r & mask_r} :
    ra == `OFF_OVERFLOW ? {28'h0, ovf_r} :
    ra == `OFF_TRIG_SEL ? {16'h0, trig_sel_r} :
    ra == `OFF_UNDERFLOW ? {28'h0, unf_r} :
    ra == `OFF_PRIORITY ? prio_r :
    ra == `OFF_AVERAGE ? {29'h0, avg_r} :
    r_seq_area && r_sub == `SUB_INPUT_SEL ? in_sel_r[r_seq] :
    r_seq_area && r_sub == `SUB_STEP_CTL ? ctl_r[r_seq] :
    r_seq_area && r_sub == `SUB_RESULT ? {22'h0, mem_r[r_seq][tail_r[r_seq]]} :
    r_seq_area && r_sub == `SUB_FIFO_STAT ? fstat[r_seq] : 32'h0;
  wire rd_ok = ra <= `OFF_PRIORITY && ra != 12'h01c || ra == `OFF_AVERAGE
               || (r_seq_area && r_sub <= `SUB_FIFO_STAT);
  wire wr_ok = wa <= `OFF_PRIORITY && wa != 12'h01c && wa != `OFF_RAW_INT || wa == `OFF_INITIATE
               || wa == `OFF_AVERAGE || (w_seq_area && w_sub <= `SUB_STEP_CTL);
  // axi4-lite handshakes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= 12'h0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_r) begin
        awaddr_r <= s_axi_awaddr;
        aw_full_r <= 1'b1;
        awready_r <= 1'b0;
      end
      if (s_axi_wvalid && wready_r) begin
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
        w_full_r <= 1'b1;
        wready_r <= 1'b0;
      end
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
        aw_full_r <= 1'b0;
        w_full_r <= 1'b0;
        awready_r <= 1'b1;
        wready_r <= 1'b1;
      end
      if (rd_go) begin
        arready_r <= 1'b0;
        rvalid_r <= 1'b1;
        rdata_r <= rd_val;
        rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
        arready_r <= 1'b1;
      end
    end
  end
  // software-visible registers; hardware sets win over clears
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      active_r <= 4'h0;
      mask_r <= 4'h0;
      raw_r <= 4'h0;
      ovf_r <= 4'h0;
      unf_r <= 4'h0;
      trig_sel_r <= 16'h0;
      prio_r <= `RST_PRIORITY;
      avg_r <= 3'h0;
      for (int i = 0; i < 4; i++) begin
        in_sel_r[i] <= 32'h0;
        ctl_r[i] <= (i == 3) ? `RST_STEP_CTL3 : 32'h0;
      end
    end else begin
      raw_r <= (raw_r & ~clr_int) | int_set;
      ovf_r <= (ovf_r & ~clr_ovf) | ovf_set;
      unf_r <= (unf_r & ~clr_unf) | unf_set;
      if (wr_go) begin
        case (wa)
          `OFF_ACTIVE: active_r <= (active_r & ~wmask[3:0]) | wval[3:0];
          `OFF_INT_MASK: mask_r <= (mask_r & ~wmask[3:0]) | wval[3:0];
          `OFF_TRIG_SEL: trig_sel_r <= (trig_sel_r & ~wmask[15:0]) | wval[15:0];
          `OFF_PRIORITY: prio_r <= ((prio_r & ~wmask) | wval) & 32'h0000_3333;
          `OFF_AVERAGE: begin
            if (wmask[0])
              avg_r <= (wval[2:0] > `MAX_AVG_LOG2) ? `MAX_AVG_LOG2 : wval[2:0];
          end
          default: begin
            if (w_seq_area && w_sub == `SUB_INPUT_SEL)
              in_sel_r[w_seq] <= (in_sel_r[w_seq] & ~wmask) | wval;
            if (w_seq_area && w_sub == `SUB_STEP_CTL)
              ctl_r[w_seq] <= (ctl_r[w_seq] & ~wmask) | wval;
          end
        endcase
      end
    end
  end
  // pin synchronisers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_s1_r <= 4'h0;
      trig_s2_r <= 4'h0;
      trig_s3_r <= 4'h0;
      done_s1_r <= 1'b0;
      done_s2_r <= 1'b0;
      done_s3_r <= 1'b0;
      data_s1_r <= 10'h0;
      data_s2_r <= 10'h0;
      div_r <= 2'h0;
    end else begin
      trig_s1_r <= periph_trig;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
      done_s1_r <= conv_done;
      done_s2_r <= done_s1_r;
      done_s3_r <= done_s2_r;
      data_s1_r <= conv_data;
      data_s2_r <= data_s1_r;
      div_r <= tick ? 2'h0 : div_r + 2'h1;
    end
  end
  // sequencing engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= S_IDLE;
      pend_r <= 4'h0;
      cur_r <= 2'd0;
      step_r <= 3'h0;
      avg_cnt_r <= 7'h0;
      acc_r <= 16'h0;
      start_r <= 1'b0;
      chan_r <= 3'h0;
      chan_diff_r <= 1'b0;
      temp_r <= 1'b0;
      irq_r <= 4'h0;
    end else begin
      pend_r <= (pend_r | (trig_ev & active_r)) & active_r & ~start_clr;
      irq_r <= raw_r & mask_r;
      start_r <= 1'b0;
      case (state_r)
        S_IDLE: begin
          if (found && active_r[pick]) begin
            cur_r <= pick;
            step_r <= 3'h0;
            avg_cnt_r <= avg_total;
            acc_r <= 16'h0;
            state_r <= S_START;
          end
        end
        S_START: begin
          if (tick) begin
            start_r <= 1'b1;
            chan_diff_r <= nib_ctl[`CTL_DIFF];
            temp_r <= nib_ctl[`CTL_TEMP];
            chan_r <= nib_ctl[`CTL_DIFF] ? {nib_in[1:0], 1'b0} : nib_in[2:0];
            state_r <= S_WAIT;
          end
        end
        S_WAIT: begin
          if (done_ev) begin
            acc_r <= acc_sum;
            avg_cnt_r <= avg_cnt_r - 7'h1;
            state_r <= S_STORE;
          end
        end
        S_STORE: begin
          if (avg_cnt_r != 7'h0) begin
            state_r <= S_START;
          end else if (seq_end || !active_r[cur_r]) begin
            state_r <= S_IDLE;
          end else begin
            step_r <= step_r + 3'h1;
            avg_cnt_r <= avg_total;
            acc_r <= 16'h0;
            state_r <= S_START;
          end
        end
        default: state_r <= S_IDLE;
      endcase
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign conv_start = start_r;
  assign conv_channel = chan_r;
  assign conv_diff = chan_diff_r;
  assign conv_temp = temp_r;
  assign seq_irq = irq_r;

  a_irq_masked: assert property (@(posedge aclk) disable iff (!aresetn)
    ##1 seq_irq == $past(raw_r & mask_r)) else $error("irq not raw and mask");
  a_clear_one: assert property (@(posedge aclk) disable iff (!aresetn)
    (clr_int[0] && !int_set[0]) |=> !raw_r[0]) else $error("w1c did not clear");
  a_set_wins: assert property (@(posedge aclk) disable iff (!aresetn)
    int_set[1] |=> raw_r[1]) else $error("step interrupt lost");
  a_prio_reset: assert property (@(posedge aclk)
    !aresetn |=> prio_r == `RST_PRIORITY) else $error("priority reset value wrong");
  a_run_enabled: assert property (@(posedge aclk) disable iff (!aresetn)
    state_r == S_IDLE && (pend_r & active_r) == 4'h0 |=> state_r == S_IDLE)
    else $error("disabled sequencer started");
  a_fifo_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_r[3] <= 4'h1 && cnt_r[0] <= 4'h8) else $error("fifo count exceeds depth");
  a_overflow_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    ovf_set[3] && !pop[3] |=> ovf_r[3] && $stable(cnt_r[3])) else $error("overflow not flagged");
  a_underflow_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    unf_set[0] |=> unf_r[0] && s_axi_rvalid) else $error("underflow not flagged");
  a_diff_even: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_start && conv_diff |-> conv_channel[0] == 1'b0) else $error("odd diff channel");
  a_start_paced: assert property (@(posedge aclk) disable iff (!aresetn)
    conv_start |=> !conv_start ##1 !conv_start) else $error("conversions too close");
endmodule

// >>> adc_conv_core_model.sv
`timescale 1ns/1ps
module adc_conv_core_model (
  input wire logic aclk, // clock
  input wire logic conv_start, // conversion request
  input wire logic [2:0] conv_channel, // selected input
  input wire logic conv_diff, // differential mode
  input wire logic conv_temp, // temperature sensor
  input wire logic [2:0] dly, // extra answer delay
  output logic conv_done, // done level
  output logic [9:0] conv_data, // result code
  output int n_conv // conversions finished
);
  int cnt;
  logic [9:0] val;
  initial begin
    conv_done = 1'b0;
    conv_data = 10'h155;
    n_conv = 0;
    cnt = 0;
    val = 10'h000;
  end
  // slow or prompt answer; done is a two-cycle level, low between samples
  always @(posedge aclk) begin
    if (conv_start) begin
      conv_data <= ~conv_data; // stale result no longer held
      val <= conv_temp ? 10'h2aa : {3'h5, conv_diff, 1'b0, conv_channel, 2'b01};
      cnt <= 5 + dly;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      if (cnt == 4) begin
        conv_data <= val;
      end
      if (cnt == 3) begin
        conv_done <= 1'b1;
        n_conv <= n_conv + 1;
      end
      if (cnt == 1) begin
        conv_done <= 1'b0;
      end
    end
  end
endmodule

// >>> adc_sample_sequencer_control_tb.sv
`timescale 1ns/1ps
`include "adc_seq_defs.svh"
module adc_sample_sequencer_control_tb;
  import adc_seq_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic [11:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata;
  logic awready, wready, bvalid, arready, rvalid, conv_start, conv_diff, conv_temp, conv_done;
  logic [1:0] bresp, rresp;
  logic [3:0] periph_trig = 0, seq_irq, wstrb = 4'hf;
  logic [2:0] conv_channel, dly = 0;
  sample_t conv_data;
  int m_conv, base, error_cnt = 0, n_compared = 0, cyc = 0, seed = 82410;
  typedef struct {logic [31:0] d; logic [31:0] m; logic [1:0] r;} rexp_s;
  rexp_s rd_q[$];
  logic [2:0] ch_q[$];
  logic [31:0] e0[5];
  logic [11:0] ra[14] = '{12'h000, 12'h004, 12'h008, 12'h00c, 12'h010, 12'h014, 12'h018,
    12'h020, 12'h030, 12'h040, 12'h044, 12'h0a4, 12'h04c, 12'h0ac};
  logic [31:0] rv[14] = '{0, 0, 0, 0, 0, 0, 0, 32'h3210, 0, 0, 0, 32'h2, 32'h100, 32'h100};
  always #10 aclk = ~aclk;
  adc_sample_sequencer_control dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .periph_trig(periph_trig), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_diff(conv_diff), .conv_temp(conv_temp), .conv_done(conv_done),
    .conv_data(conv_data), .seq_irq(seq_irq));
  adc_conv_core_model model_u (.aclk(aclk), .conv_start(conv_start),
    .conv_channel(conv_channel), .conv_diff(conv_diff), .conv_temp(conv_temp), .dly(dly),
    .conv_done(conv_done), .conv_data(conv_data), .n_conv(m_conv));
  task chk(string nm, logic [31:0] seen, logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task end_sim;
    if (error_cnt == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task tick(int n);
    repeat (n) @(posedge aclk);
  endtask
  task wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
    logic aw_t, w_t;
    aw_t = 0;
    w_t = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw_t && w_t)) begin
      @(posedge aclk);
      if (awvalid && awready) begin
        aw_t = 1;
        awvalid <= 0;
      end
      if (wvalid && wready) begin
        w_t = 1;
        wvalid <= 0;
      end
    end
    while (!bvalid) @(posedge aclk);
    chk("bresp", {30'h0, bresp}, {30'h0, er});
  endtask
  task rd(logic [11:0] a, logic [31:0] e, logic [31:0] m, logic [1:0] er);
    rd_q.push_back('{e, m, er});
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 0;
    end while (!rvalid);
  endtask
  task wait_conv(int n);
    int i;
    for (i = 0; i < 3000 && m_conv < n; i++) @(posedge aclk);
    tick(12);
  endtask
  task pulse(int b);
    periph_trig[b] <= 1;
    tick(4);
    periph_trig[b] <= 0;
    tick(20);
  endtask
  function automatic logic [11:0] sa(int n, int s);
    return 12'(`OFF_SEQ_BASE + `OFF_SEQ_STRIDE * n + 4 * s);
  endfunction
  function automatic logic [31:0] cd(logic [2:0] ch, logic d);
    return {22'h0, 3'h5, d, 1'b0, ch, 2'b01};
  endfunction
  // read answers are matched against the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      chk("rdata", rdata & rd_q[0].m, rd_q[0].d & rd_q[0].m);
      chk("rresp", {30'h0, rresp}, {30'h0, rd_q[0].r});
      void'(rd_q.pop_front());
    end
    if (conv_start && ch_q.size() > 0) chk("channel", {29'h0, conv_channel}, {29'h0, ch_q.pop_front()});
  end
  always @(posedge aclk) begin
    dly <= 3'({$random(seed)} % 5);
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_sim();
    end
  end
  initial begin
    tick(4);
    aresetn <= 1;
    for (int k = 0; k < 14; k++) rd(ra[k], rv[k], '1, `RESP_OKAY);
    rd(12'h0fc, 0, 0, `RESP_SLVERR);
    rd(`OFF_INITIATE, 0, 0, `RESP_SLVERR);
    wr(`OFF_RAW_INT, 1, `RESP_SLVERR);
    // peripheral trigger ignored while disabled, taken once enabled
    wr(sa(1, 0), 32'h4, `RESP_OKAY);
    wr(sa(1, 1), 32'h2, `RESP_OKAY);
    wr(`OFF_TRIG_SEL, 32'h40, `RESP_OKAY);
    pulse(3);
    rd(sa(1, 3), 32'h100, '1, `RESP_OKAY);
    wr(`OFF_ACTIVE, 32'h2, `RESP_OKAY);
    base = m_conv;
    pulse(3);
    wait_conv(base + 1);
    rd(sa(1, 3), 32'h010, '1, `RESP_OKAY);
    rd(sa(1, 2), cd(4, 0), '1, `RESP_OKAY);
    rd(`OFF_RAW_INT, 0, '1, `RESP_OKAY);
    // eight-step unit ending at step five, differential step, every step interrupting
    wr(sa(0, 0), 32'h1115_0732, `RESP_OKAY);
    wr(sa(0, 1), 32'h0006_4454, `RESP_OKAY);
    wr(`OFF_INT_MASK, 32'h1, `RESP_OKAY);
    wr(`OFF_ACTIVE, 32'h1, `RESP_OKAY);
    base = m_conv;
    wr(`OFF_INITIATE, 32'h1, `RESP_OKAY);
    wait_conv(base + 5);
    tick(30);
    chk("conv count", 32'(m_conv), 32'(base + 5));
    rd(sa(0, 3), 32'h050, '1, `RESP_OKAY);
    rd(`OFF_RAW_INT, 32'h1, '1, `RESP_OKAY);
    chk("seq_irq", {28'h0, seq_irq}, 32'h1);
    wr(`OFF_INT_CLEAR, 32'h0, `RESP_OKAY);
    rd(`OFF_RAW_INT, 32'h1, '1, `RESP_OKAY);
    wr(`OFF_INT_CLEAR, 32'h1, `RESP_OKAY);
    rd(`OFF_RAW_INT, 32'h0, '1, `RESP_OKAY);
    tick(3);
    chk("seq_irq", {28'h0, seq_irq}, 32'h0);
    e0 = '{cd(2, 0), cd(6, 1), cd(7, 0), cd(0, 0), cd(5, 0)};
    foreach (e0[k]) rd(sa(0, 2), e0[k], '1, `RESP_OKAY);
    rd(sa(0, 3), 32'h155, '1, `RESP_OKAY);
    rd(sa(0, 2), 0, 0, `RESP_OKAY);
    rd(`OFF_UNDERFLOW, 32'h1, '1, `RESP_OKAY);
    wr(`OFF_UNDERFLOW, 32'h1, `RESP_OKAY);
    rd(`OFF_UNDERFLOW, 32'h0, '1, `RESP_OKAY);
    // two sequencers initiated at once, priority distinct and reordered
    wr(`OFF_PRIORITY, 32'h2013, `RESP_OKAY);
    wr(sa(2, 0), 32'h5, `RESP_OKAY);
    wr(sa(2, 1), 32'h6, `RESP_OKAY);
    wr(sa(1, 0), 32'h3, `RESP_OKAY);
    wr(sa(1, 1), 32'h6, `RESP_OKAY);
    wr(`OFF_TRIG_SEL, 32'h0, `RESP_OKAY);
    wr(`OFF_INT_MASK, 32'h0, `RESP_OKAY);
    wr(`OFF_ACTIVE, 32'h6, `RESP_OKAY);
    ch_q.push_back(3'h5);
    ch_q.push_back(3'h3);
    base = m_conv;
    wr(`OFF_INITIATE, 32'h6, `RESP_OKAY);
    wait_conv(base + 2);
    rd(`OFF_RAW_INT, 32'h6, '1, `RESP_OKAY);
    rd(`OFF_INT_CLEAR, 32'h0, '1, `RESP_OKAY);
    chk("seq_irq", {28'h0, seq_irq}, 32'h0);
    rd(sa(2, 2), cd(5, 0), '1, `RESP_OKAY);
    rd(sa(1, 2), cd(3, 0), '1, `RESP_OKAY);
    wr(`OFF_INT_CLEAR, 32'h6, `RESP_OKAY);
    rd(`OFF_RAW_INT, 32'h0, '1, `RESP_OKAY);
    // always trigger on the one-entry unit until it overflows
    wr(sa(3, 0), 32'h7, `RESP_OKAY);
    wr(sa(3, 1), 32'ha, `RESP_OKAY);
    wr(`OFF_TRIG_SEL, 32'hf000, `RESP_OKAY);
    wr(`OFF_ACTIVE, 32'h8, `RESP_OKAY);
    wait_conv(m_conv + 3);
    wr(`OFF_ACTIVE, 32'h0, `RESP_OKAY);
    tick(30);
    rd(`OFF_OVERFLOW, 32'h8, '1, `RESP_OKAY);
    rd(sa(3, 3), 32'h1000, 32'h1100, `RESP_OKAY);
    rd(sa(3, 2), 32'h2aa, '1, `RESP_OKAY);
    rd(sa(3, 3), 32'h0100, 32'h1100, `RESP_OKAY);
    wr(`OFF_OVERFLOW, 32'h8, `RESP_OKAY);
    rd(`OFF_OVERFLOW, 32'h0, '1, `RESP_OKAY);
    // averaging four conversions into one entry
    wr(`OFF_TRIG_SEL, 32'h0, `RESP_OKAY);
    wr(`OFF_AVERAGE, 32'h7, `RESP_OKAY);
    rd(`OFF_AVERAGE, 32'h6, '1, `RESP_OKAY);
    wr(`OFF_AVERAGE, 32'h2, `RESP_OKAY);
    wr(sa(3, 1), 32'h2, `RESP_OKAY);
    wr(`OFF_ACTIVE, 32'h8, `RESP_OKAY);
    base = m_conv;
    wr(`OFF_INITIATE, 32'h8, `RESP_OKAY);
    wait_conv(base + 4);
    tick(30);
    chk("avg count", 32'(m_conv), 32'(base + 4));
    rd(sa(3, 2), cd(7, 0), '1, `RESP_OKAY);
    rd(sa(3, 3), 32'h0100, 32'h1100, `RESP_OKAY);
    // byte strobes: only the second byte lands, upper nibble bits are dropped
    wstrb <= 4'h2;
    wr(`OFF_PRIORITY, 32'h0000_0732, `RESP_OKAY);
    wstrb <= 4'hf;
    rd(`OFF_PRIORITY, 32'h0000_0313, '1, `RESP_OKAY);
    end_sim();
  end
endmodule
